/* pio_cell.sv */
/*
  pio_cell: one programmable i/o cell between core fabric and a pad.
  Assumes one 10 MHz clk_i; both side clocks and the pad are asynchronous
  pins, all sampled here and the side clocks edge-detected; core inputs are synchronous to clk_i.
*/
`timescale 1ns/10ps
module pio_cell
  import pio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o,
  output logic pull_up_o,
  output logic pull_down_o,
  input wire logic capture_side_clock_i,
  input wire logic launch_side_clock_i,
  input wire pio_mode_t mode_i,
  input wire logic config_active_i,
  input wire logic pin_used_i,
  input wire logic pull_down_sel_i,
  input wire logic rx_reg_en_i,
  input wire logic tx_reg_en_i,
  input wire logic oe_reg_en_i,
  input wire logic rx_edge_i,
  input wire logic tx_edge_i,
  input wire logic oe_edge_i,
  input wire logic tx_inv_i,
  input wire pio_dest_t bypass_dest_i,
  input wire logic tx_data_i,
  input wire logic drive_en_i,
  output logic rx_data_o,
  output logic global_clock_net_o,
  output logic global_control_net_o,
  output logic synth_reference_feed_o
);

  logic pad_lvl;
  logic cap_lvl;
  logic lau_lvl;
  logic rx_tick;
  logic tx_tick;
  logic oe_tick;
  logic rx_cap_r;
  logic tx_reg_r;
  logic oe_reg_r;
  logic rx_path_en;
  logic tx_path_en;
  logic bypass_en;
  logic tx_val;
  logic oe_val;
  logic pad_nxt;
  logic oe_nxt;

  // pin-side inputs all pass the three-flop filter
  pio_sync #(.RST_VAL(PIO_PAD_RST)) u_pad_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(pad_i),
    .level_o(pad_lvl)
  );

  pio_sync #(.RST_VAL(PIO_CLK_RST)) u_cap_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(capture_side_clock_i),
    .level_o(cap_lvl)
  );

  pio_sync #(.RST_VAL(PIO_CLK_RST)) u_lau_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(launch_side_clock_i),
    .level_o(lau_lvl)
  );

  pio_edge u_rx_edge (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .level_i(cap_lvl),
    .edge_sel_i(rx_edge_i),
    .tick_o(rx_tick)
  );

  pio_edge u_tx_edge (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .level_i(lau_lvl),
    .edge_sel_i(tx_edge_i),
    .tick_o(tx_tick)
  );

  pio_edge u_oe_edge (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .level_i(lau_lvl),
    .edge_sel_i(oe_edge_i),
    .tick_o(oe_tick)
  );

  // path enables by mode
  // path selection
  assign rx_path_en = (mode_i == PIO_MODE_IN) || (mode_i == PIO_MODE_BIDIR);
  assign tx_path_en = (mode_i == PIO_MODE_OUT) || (mode_i == PIO_MODE_BIDIR);
  assign bypass_en = (mode_i == PIO_MODE_IN) && !rx_reg_en_i;

  // receive register, clocked by the capture side
  // capture pad first
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rx_cap_r <= PIO_DATA_RST;
    else if (rx_tick && rx_path_en)
      rx_cap_r <= pad_lvl;
  end

  // transmit register, clocked by the launch side
  // launch-clocked transmit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tx_reg_r <= PIO_DATA_RST;
    else if (tx_tick && tx_path_en)
      tx_reg_r <= tx_data_i;
  end

  // drive-enable register, also launch side with its own edge
  // registered enable
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      oe_reg_r <= PIO_EN_RST;
    else if (oe_tick && (mode_i == PIO_MODE_BIDIR))
      oe_reg_r <= drive_en_i;
  end

  // value and enable heading for the pad
  always_comb
  begin
    tx_val = tx_reg_en_i ? tx_reg_r : tx_data_i;
    if (tx_path_en && tx_inv_i)
      tx_val = ~tx_val;
    oe_val = 1'h0;
    pad_nxt = tx_val;
    unique case (mode_i)
      PIO_MODE_IN:
        oe_val = 1'h0;
      PIO_MODE_OUT:
        oe_val = 1'h1;
      PIO_MODE_BIDIR:
        oe_val = oe_reg_en_i ? oe_reg_r : drive_en_i;
      PIO_MODE_CLKOUT:
      begin
        oe_val = 1'h1;
        pad_nxt = lau_lvl;
      end
    endcase
    oe_nxt = oe_val && !config_active_i && pin_used_i;
  end

  // pad drive flops; the board sees a one-cycle registered copy
  // float when not enabled
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pad_o <= PIO_DATA_RST;
      pad_oe_o <= PIO_EN_RST;
    end
    else
    begin
      pad_o <= pad_nxt;
      pad_oe_o <= oe_nxt;
    end
  end

  // weak pulls: pull-up while configuring, chosen pull when unused
  // pull control
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pull_up_o <= PIO_PULL_UP_RST;
      pull_down_o <= 1'h0;
    end
    else if (config_active_i)
    begin
      pull_up_o <= 1'h1;
      pull_down_o <= 1'h0;
    end
    else if (!pin_used_i)
    begin
      pull_up_o <= !pull_down_sel_i;
      pull_down_o <= pull_down_sel_i;
    end
    else
    begin
      pull_up_o <= 1'h0;
      pull_down_o <= 1'h0;
    end
  end

  // data to the core; in input and bidirectional modes with the receive register off, pad level keeps flowing even while floating
  // receive output
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rx_data_o <= PIO_DATA_RST;
    else if (!rx_path_en)
      rx_data_o <= 1'h0;
    else
      rx_data_o <= rx_reg_en_i ? rx_cap_r : pad_lvl;
  end

  // bypass feed skips the receive register; only the pin filter and one output flop are in the way,
  // which costs latency but keeps metastability out of the nets
  // bypass destinations
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      global_clock_net_o <= 1'h0;
      global_control_net_o <= 1'h0;
      synth_reference_feed_o <= 1'h0;
    end
    else
    begin
      global_clock_net_o <= bypass_en && (bypass_dest_i == PIO_DEST_CLOCK_NET) && pad_lvl;
      global_control_net_o <= bypass_en && (bypass_dest_i == PIO_DEST_CONTROL_NET) && pad_lvl;
      synth_reference_feed_o <= bypass_en && (bypass_dest_i == PIO_DEST_SYNTH_REF) && pad_lvl;
    end
  end

  // checks on the cell's outputs and its receive and transmit registers
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_cfg_pullup;
    config_active_i |=> pull_up_o && !pull_down_o && !pad_oe_o;
  endproperty
  a_cfg_pullup: assert property (p_cfg_pullup) else $error("pin not weak pull-up in configuration");

  property p_unused_pull;
    (!config_active_i && !pin_used_i) |=> !pad_oe_o && (pull_down_o == $past(pull_down_sel_i))
      && (pull_up_o == !$past(pull_down_sel_i));
  endproperty
  a_unused_pull: assert property (p_unused_pull) else $error("unused pin pull wrong");

  property p_bypass_gated;
    rx_reg_en_i |=> !global_clock_net_o && !global_control_net_o && !synth_reference_feed_o;
  endproperty
  a_bypass_gated: assert property (p_bypass_gated) else $error("bypass active with receive register");

  property p_bypass_follow;
    (bypass_en && bypass_dest_i == PIO_DEST_SYNTH_REF) |=> synth_reference_feed_o == $past(pad_lvl)
      && !global_clock_net_o;
  endproperty
  a_bypass_follow: assert property (p_bypass_follow) else $error("bypass feed misrouted");

  property p_out_inv;
    (mode_i == PIO_MODE_OUT && !tx_reg_en_i && pin_used_i && !config_active_i)
      |=> pad_oe_o && (pad_o == ($past(tx_data_i) ^ $past(tx_inv_i)));
  endproperty
  a_out_inv: assert property (p_out_inv) else $error("output value or inversion wrong");

  property p_in_nodrive;
    (mode_i == PIO_MODE_IN) |=> !pad_oe_o;
  endproperty
  a_in_nodrive: assert property (p_in_nodrive) else $error("input mode drives pad");

  property p_rx_capture;
    (rx_tick && rx_path_en) |=> rx_cap_r == $past(pad_lvl);
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("receive register missed capture");

  property p_tx_hold;
    !tx_tick |=> tx_reg_r == $past(tx_reg_r);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit register changed off edge");

  property p_oe_off;
    (mode_i == PIO_MODE_BIDIR && !oe_reg_en_i && !drive_en_i) |=> !pad_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pad driven with enable low");

  property p_rx_float;
    (mode_i == PIO_MODE_BIDIR && !rx_reg_en_i) |=> rx_data_o == $past(pad_lvl);
  endproperty
  a_rx_float: assert property (p_rx_float) else $error("receive path lost pad level");

  property p_clkout;
    (mode_i == PIO_MODE_CLKOUT && pin_used_i && !config_active_i) |=> pad_oe_o && pad_o == $past(lau_lvl);
  endproperty
  a_clkout: assert property (p_clkout) else $error("clock output not following tree");

  property p_cov_bidir_rx;
    mode_i == PIO_MODE_BIDIR && rx_reg_en_i && rx_tick;
  endproperty
  c_cov_bidir_rx: cover property (p_cov_bidir_rx);

  property p_cov_bypass;
    bypass_en && pad_lvl ##1 global_clock_net_o;
  endproperty
  c_cov_bypass: cover property (p_cov_bypass);

  property p_cov_oe_reg;
    mode_i == PIO_MODE_BIDIR && oe_reg_en_i && oe_tick ##1 pad_oe_o;
  endproperty
  c_cov_oe_reg: cover property (p_cov_oe_reg);

endmodule

/* pio_pkg.sv */
/*
  pio_pkg: shared constants and types for the programmable i/o cell.
  Assumes every file of the cell imports it whole; holds no logic.
*/
package pio_pkg;

  // cell operating modes, picked by the configuration inputs
  typedef enum logic [1:0] {
    PIO_MODE_IN,
    PIO_MODE_OUT,
    PIO_MODE_BIDIR,
    PIO_MODE_CLKOUT
  } pio_mode_t;

  // destinations of the bypass feed that skips the receive register
  typedef enum logic [1:0] {
    PIO_DEST_CLOCK_NET,
    PIO_DEST_CONTROL_NET,
    PIO_DEST_SYNTH_REF
  } pio_dest_t;

  // synchroniser depth for every pin-side input
  localparam int unsigned PIO_SYNC_STAGES = 3;

  // reset levels: an idle pad reads high because of the weak pull-up
  localparam logic PIO_PAD_RST = 1'h1;
  localparam logic PIO_CLK_RST = 1'h0;
  localparam logic PIO_DATA_RST = 1'h0;
  localparam logic PIO_EN_RST = 1'h0;
  localparam logic PIO_PULL_UP_RST = 1'h1;

  // edge select encoding of the per-register trigger inputs
  localparam logic PIO_EDGE_RISE = 1'h0;
  localparam logic PIO_EDGE_FALL = 1'h1;

endpackage

/* pio_sync.sv */
/*
  pio_sync: three-flop synchroniser with an agreement filter.
  Assumes the input is asynchronous to clk_i; the filtered level changes
  only once the second and third stages agree.
*/
`timescale 1ns/10ps
module pio_sync
  import pio_pkg::*;
#(
  parameter logic RST_VAL = 1'h0
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic async_i,
  output logic level_o
);

  logic [PIO_SYNC_STAGES-1:0] stage_r;

  // shift chain; only stage 1 reads stage 0
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      stage_r <= {PIO_SYNC_STAGES{RST_VAL}};
    else
      stage_r <= {stage_r[PIO_SYNC_STAGES-2:0], async_i};
  end

  // accept a new level only when stages two and three agree
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      level_o <= RST_VAL;
    else if (stage_r[1] == stage_r[2])
      level_o <= stage_r[2];
  end

endmodule

/* pio_edge.sv */
/*
  pio_edge: turns a filtered clock level into a one-cycle enable pulse
  on its rising or falling edge, as selected.
  Assumes the level is already synchronous to clk_i.
*/
`timescale 1ns/10ps
module pio_edge
  import pio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic level_i,
  input wire logic edge_sel_i,
  output logic tick_o
);

  logic prev_r;

  // remember last level to spot transitions
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      prev_r <= PIO_CLK_RST;
    else
      prev_r <= level_i;
  end

  // pulse on the chosen transition only
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tick_o <= 1'h0;
    else if (edge_sel_i == PIO_EDGE_FALL)
      tick_o <= prev_r & ~level_i;
    else
      tick_o <= ~prev_r & level_i;
  end

endmodule

/* pio_pad_model.sv */
/*
  pio_pad_model: the board signal at the i/o pad of one cell.
  Assumes the cell's drive, enable and pull outputs come straight in;
  the bench decides whether the board drives its own level.
*/
`timescale 1ns/10ps
module pio_pad_model
(
  input wire logic clk_i,
  input wire logic pad_o_i,
  input wire logic pad_oe_i,
  input wire logic pull_up_i,
  input wire logic pull_down_i,
  input wire logic ext_en_i,
  input wire logic ext_val_i,
  output logic pad_o
);
  logic float_r = 1'h0;

  // a pad nobody holds keeps changing, so a stale level never reads as valid
  always @(posedge clk_i)
    float_r <= ~float_r;

  always_comb
  begin
    if (pad_oe_i)
      pad_o = pad_o_i;
    else if (ext_en_i)
      pad_o = ext_val_i; // board drives only while the cell floats
    else if (pull_up_i)
      pad_o = 1'h1;
    else if (pull_down_i)
      pad_o = 1'h0;
    else
      pad_o = float_r;
  end
endmodule

/* pio_cell_tb.sv */
/*
  pio_cell_tb: self-checking bench for the programmable i/o cell.
  Assumes the pad model closes the pad loop; side clocks are slow pulses
  that stay well inside the cell's sampling limit.
*/
`timescale 1ns/10ps
module pio_cell_tb
  import pio_pkg::*;
;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic cap_clk = 1'h0, lau_clk = 1'h0, cfg = 1'h1, used = 1'h0, pd_sel = 1'h0;
  logic rx_reg = 1'h0, tx_reg = 1'h0, oe_reg = 1'h0, rx_e = 1'h0, tx_e = 1'h0, oe_e = 1'h0;
  logic inv = 1'h0, txd = 1'h0, den = 1'h0, ext_en = 1'h0, ext_val = 1'h0;
  pio_mode_t mode = PIO_MODE_IN;
  pio_dest_t dest = PIO_DEST_CLOCK_NET;
  logic pad, pad_o, pad_oe, pu, pdn, rxd, gcn, gctl, srf;
  int num_errors = 0;
  int n_checks = 0;

  // 100 ns clock
  always #50 clk = ~clk;

  pio_cell dut_u (.clk_i(clk), .rst_b_i(rst_b), .pad_i(pad), .pad_o(pad_o), .pad_oe_o(pad_oe),
    .pull_up_o(pu), .pull_down_o(pdn), .capture_side_clock_i(cap_clk), .launch_side_clock_i(lau_clk),
    .mode_i(mode), .config_active_i(cfg), .pin_used_i(used), .pull_down_sel_i(pd_sel),
    .rx_reg_en_i(rx_reg), .tx_reg_en_i(tx_reg), .oe_reg_en_i(oe_reg), .rx_edge_i(rx_e),
    .tx_edge_i(tx_e), .oe_edge_i(oe_e), .tx_inv_i(inv), .bypass_dest_i(dest), .tx_data_i(txd),
    .drive_en_i(den), .rx_data_o(rxd), .global_clock_net_o(gcn), .global_control_net_o(gctl),
    .synth_reference_feed_o(srf));

  pio_pad_model pad_u (.clk_i(clk), .pad_o_i(pad_o), .pad_oe_i(pad_oe), .pull_up_i(pu),
    .pull_down_i(pdn), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one bit result against its expected level
  task automatic chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: got %b expected %b", $time, got, exp);
    end
  endtask

  // moves a side clock and leaves time for sampling and the register path
  task automatic side(input logic cap, input logic lvl);
    if (cap)
      cap_clk = lvl;
    else
      lau_clk = lvl;
    cyc(12);
  endtask

  task automatic complete_run();
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the sequence needs about 410 cycles
  initial
  begin
    #1000000;
    num_errors++;
    complete_run();
  end

  // main sequence, all inputs moved at the falling edge
  initial
  begin
    cyc(16);
    rst_b = 1'h1;
    cyc(3);
    chk(pad_oe, 1'h0);
    chk(pu, 1'h1);
    mode = PIO_MODE_OUT;
    txd = 1'h1;
    cyc(4);
    chk(pad_oe, 1'h0);
    chk(pu, 1'h1);
    cfg = 1'h0;
    cyc(4);
    chk(pad_oe, 1'h0);
    chk(pu, 1'h1);
    pd_sel = 1'h1;
    cyc(4);
    chk(pu, 1'h0);
    chk(pdn, 1'h1);
    used = 1'h1;
    cyc(4);
    chk(pad_oe, 1'h1);
    chk(pad_o, 1'h1);
    inv = 1'h1;
    cyc(4);
    chk(pad_o, 1'h0);
    chk(rxd, 1'h0);
    // registered transmit, rising then falling edge
    inv = 1'h0;
    tx_reg = 1'h1;
    side(1'h0, 1'h1);
    chk(pad_o, 1'h1);
    txd = 1'h0;
    side(1'h0, 1'h0);
    chk(pad_o, 1'h1);
    side(1'h0, 1'h1);
    chk(pad_o, 1'h0);
    tx_e = 1'h1;
    txd = 1'h1;
    side(1'h0, 1'h0);
    chk(pad_o, 1'h1);
    txd = 1'h0;
    side(1'h0, 1'h1);
    chk(pad_o, 1'h1);
    side(1'h0, 1'h0);
    chk(pad_o, 1'h0);
    // input mode, bypass feed to each destination
    mode = PIO_MODE_IN;
    tx_reg = 1'h0;
    ext_en = 1'h1;
    for (int d = 0; d < 3; d++)
    begin
      dest = pio_dest_t'(d);
      ext_val = 1'h1;
      cyc(12);
      chk(pad_oe, 1'h0);
      chk(rxd, 1'h1);
      chk(gcn, d == 0);
      chk(gctl, d == 1);
      chk(srf, d == 2);
      ext_val = 1'h0;
      cyc(12);
      chk(rxd, 1'h0);
      chk(gcn | gctl | srf, 1'h0);
    end
    // registered receive blocks the bypass and waits for the capture edge
    dest = PIO_DEST_CLOCK_NET;
    rx_reg = 1'h1;
    ext_val = 1'h1;
    cyc(12);
    chk(gcn, 1'h0);
    chk(rxd, 1'h0);
    side(1'h1, 1'h1);
    chk(rxd, 1'h1);
    ext_val = 1'h0;
    side(1'h1, 1'h0);
    chk(rxd, 1'h1);
    side(1'h1, 1'h1);
    chk(rxd, 1'h0);
    // bidirectional: floating pad still read, own drive read back
    mode = PIO_MODE_BIDIR;
    rx_reg = 1'h0;
    ext_val = 1'h1;
    cyc(12);
    chk(pad_oe, 1'h0);
    chk(rxd, 1'h1);
    den = 1'h1;
    cyc(12);
    chk(pad_oe, 1'h1);
    chk(rxd, 1'h0);
    inv = 1'h1;
    cyc(12);
    chk(pad_o, 1'h1);
    // drive enable through its register, falling edge
    inv = 1'h0;
    oe_reg = 1'h1;
    oe_e = 1'h1;
    side(1'h0, 1'h1);
    side(1'h0, 1'h0);
    chk(pad_oe, 1'h1);
    den = 1'h0;
    side(1'h0, 1'h1);
    chk(pad_oe, 1'h1);
    side(1'h0, 1'h0);
    chk(pad_oe, 1'h0);
    // registered transmit beside unregistered receive
    oe_reg = 1'h0;
    den = 1'h1;
    tx_reg = 1'h1;
    tx_e = 1'h0;
    txd = 1'h1;
    side(1'h0, 1'h1);
    chk(pad_o, 1'h1);
    chk(rxd, 1'h1);
    txd = 1'h0;
    cyc(12);
    chk(pad_o, 1'h1);
    // registered receive on the falling capture edge; the board still drives high,
    // and the register keeps its older low value until the chosen edge comes
    den = 1'h0;
    rx_reg = 1'h1;
    rx_e = 1'h1;
    cyc(12);
    chk(rxd, 1'h0);
    side(1'h1, 1'h0);
    chk(rxd, 1'h1);
    ext_val = 1'h0;
    side(1'h1, 1'h1);
    chk(rxd, 1'h1);
    side(1'h1, 1'h0);
    chk(rxd, 1'h0);
    // clock output follows the launch clock
    mode = PIO_MODE_CLKOUT;
    tx_reg = 1'h0;
    side(1'h0, 1'h0);
    chk(pad_o, 1'h0);
    side(1'h0, 1'h1);
    chk(pad_o, 1'h1);
    chk(pad_oe, 1'h1);
    complete_run();
  end
endmodule
